// >>> bench/dpct_ext_src.sv
`timescale 1ns/10ps
`default_nettype none
module dpct_ext_src
(
    input  wire logic clk,      // Clock
    output var  logic ext_line  // Drives the timer input line
);
    // Idle low until the bench asks for an edge
    initial ext_line = 1'b0;
    // Held three cycles so the three-flop synchroniser cannot miss it
    task pulse();
        @(posedge clk);
        ext_line <= 1'b1;
        repeat (3) @(posedge clk);
        ext_line <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/dpct_timers_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dpct_timers_chk
(
    input wire logic clk,                 // Clock
    input wire logic sys_rst,             // Reset, high
    input wire logic wb_cyc_i,            // Bus cycle
    input wire logic wb_stb_i,            // Bus strobe
    input wire logic wb_ack_o,            // Bus acknowledge
    input wire logic timer_zero_request,  // First timer end pulse
    input wire logic timer_one_request,   // Second timer end pulse
    input wire logic serial_rate_tick,    // Serial rate pulse
    input wire logic irq                  // Level interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****************************************************
    // Handshake, request pulses and interrupt level
    // ****************************************************
    sequence s_bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack_resp; s_bus_req |=> s_ack_pulse; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack not one cycle after request");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_serial; serial_rate_tick == timer_zero_request; endproperty
    a_serial: assert property (p_serial) else $error("serial tick differs");
    property p_req0_gap; timer_zero_request |=> !timer_zero_request [*3]; endproperty
    a_req0_gap: assert property (p_req0_gap) else $error("first timer too fast");
    property p_req1_gap; timer_one_request |=> !timer_one_request [*3]; endproperty
    a_req1_gap: assert property (p_req1_gap) else $error("second timer too fast");
    property p_reset_quiet;
        $fell(sys_rst) |-> !irq && !timer_zero_request && !timer_one_request && !wb_ack_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output busy after reset");
    property p_irq_cause;
        $rose(irq) |-> $past(timer_zero_request || timer_one_request || wb_ack_o)
            || $past(timer_zero_request || timer_one_request || wb_ack_o, 2)
            || $past(timer_zero_request || timer_one_request, 3);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without event");
    property p_irq_drop; $fell(irq) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq fell without write");
endmodule
bind dpct_timers dpct_timers_chk i_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .timer_zero_request(timer_zero_request),
    .timer_one_request(timer_one_request), .serial_rate_tick(serial_rate_tick), .irq(irq));
`default_nettype wire

// >>> bench/dual_prescaled_counter_timers_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dual_prescaled_counter_timers_tb;
    logic        clk, sys_rst, cyc, stb, we, ext, olv;
    logic [31:0] adr, wdat, rd;
    wire  [31:0] dat_o;
    wire         ack, timer_output_signal, rq0, rq1, irq;
    int          checks, mismatches, n, m;
    int          pv[3] = '{2, 0, 1};
    int          lv[3] = '{3, 1, 0};
    int          gap[3] = '{24, 256, 1024};
    dpct_timers i_dpct_timers (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .timer_input_line(ext), .timer_output_line(timer_output_signal),
        .timer_zero_request(rq0), .timer_one_request(rq1), .serial_rate_tick(), .irq(irq));
    dpct_ext_src i_dpct_ext_src (.clk(clk), .ext_line(ext));
    // ****************************************************
    // Clock, bus tasks, verdict
    // ****************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Closing report, also reached by a stuck bus
    task complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Classic single cycle; held until ack is sampled
    task xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, d, 1'b1);
    endtask
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        xfer(a, 32'h0, 1'b0);
        `CHK(nm, e, rd)
    endtask
    // Edges until the chosen request pulse, capped at lim
    task wait_req(input logic one, input int lim);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((one ? rq1 : rq0) !== 1'b1 && n < lim);
    endtask
    // Main sequence
    initial
    begin
        {sys_rst, cyc, stb, we, adr, wdat, checks, mismatches} = '0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("count0", 32'h18, 32'h0);
        rdc("status", 32'h20, 32'h0);
        wr(32'h08, 32'h5);
        rdc("prescale0", 32'h08, 32'h0);
        rdc("unmapped", 32'h28, 32'h0);
        $display("test reset done");
        wr(32'h24, 32'h3);
        wr(32'h04, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(32'h08, pv[i]);
            wr(32'h10, lv[i]);
            wr(32'h00, 32'h3);
            wait_req(1'b0, 2000);
            olv = timer_output_signal;
            wait_req(1'b0, 2000);
            `CHK("interval", gap[i], n)
            `CHK("out zero", ~olv, timer_output_signal)
        end
        `CHK("irq", 1'b1, irq)
        rdc("status set", 32'h20, 32'h1);
        wr(32'h00, 32'h0);
        xfer(32'h18, 32'h0, 1'b0);
        repeat (20) @(posedge clk);
        rdc("held count", 32'h18, rd);
        wr(32'h20, 32'h1);
        rdc("status clear", 32'h20, 32'h0);
        `CHK("irq clear", 1'b0, irq)
        wr(32'h00, 32'h2);
        wait_req(1'b0, 1100);
        `CHK("resume", 1'b1, n < 1100)
        $display("test continuous done");
        wr(32'h00, 32'h0);
        wr(32'h04, 32'h0);
        wr(32'h08, 32'h1);
        wr(32'h10, 32'h1);
        wr(32'h00, 32'h3);
        wait_req(1'b0, 20);
        wait_req(1'b0, 50);
        `CHK("single pass", 50, n)
        rdc("count end", 32'h18, 32'h0);
        $display("test single done");
        wr(32'h04, 32'h2);
        wr(32'h0c, 32'h1);
        wr(32'h14, 32'h2);
        wr(32'h00, 32'h300);
        // Watch while the edge is made; one edge alone brings no request within the wait
        fork
            i_dpct_ext_src.pulse();
            wait_req(1'b1, 12);
        join
        `CHK("one edge", 12, n)
        fork
            i_dpct_ext_src.pulse();
            wait_req(1'b1, 12);
        join
        `CHK("two edges", 1'b1, n < 12)
        for (int u = 2; u < 4; u++)
        begin
            wr(32'h00, 32'h0);
            wr(32'h04, 32'h2 | (u << 3));
            wr(32'h14, 32'h8);
            wr(32'h00, 32'h200);
            wait_req(1'b1, 40);
            `CHK("no trigger", 40, n)
            i_dpct_ext_src.pulse();
            repeat (16) @(posedge clk);
            i_dpct_ext_src.pulse();
            wait_req(1'b1, 60);
            `CHK("retrigger", u == 3, n > 18)
        end
        $display("test external done");
        wr(32'h00, 32'h0);
        wr(32'h04, 32'h5);
        wr(32'h10, 32'h1);
        wr(32'h14, 32'h2);
        wr(32'h00, 32'h303);
        wait_req(1'b1, 100);
        wait_req(1'b1, 100);
        `CHK("cascade", 8, n)
        wr(32'h04, 32'h40);
        // Let the output select settle before counting edges
        @(posedge clk);
        olv = timer_output_signal;
        m = 0;
        repeat (8)
        begin
            @(posedge clk);
            m += (timer_output_signal !== olv);
            olv = timer_output_signal;
        end
        `CHK("clock out", 4, m)
        $display("test cascade and output done");
        complete_run();
    end
endmodule
`default_nettype wire

// >>> core/dpct_consts.vh
`ifndef DPCT_CONSTS_VH
`define DPCT_CONSTS_VH
// ****************************************************
// Register map (word offsets, byte address = 4 x offset)
// ****************************************************
`define DPCT_ADR_CTRL    4'h0
`define DPCT_ADR_MODE    4'h1
`define DPCT_ADR_PRE0    4'h2
`define DPCT_ADR_PRE1    4'h3
`define DPCT_ADR_LOAD0   4'h4
`define DPCT_ADR_LOAD1   4'h5
`define DPCT_ADR_CNT0    4'h6
`define DPCT_ADR_CNT1    4'h7
`define DPCT_ADR_STAT    4'h8
`define DPCT_ADR_MASK    4'h9
// ****************************************************
// Field positions
// ****************************************************
`define DPCT_CTL_LOAD    0
`define DPCT_CTL_RUN     1
`define DPCT_MOD_CONT    0
`define DPCT_MOD_SRCEXT  1
`define DPCT_MOD_CASC    2
`define DPCT_MOD_IN_LO   3
`define DPCT_MOD_IN_HI   4
`define DPCT_MOD_OUT_LO  5
`define DPCT_MOD_OUT_HI  6
// ****************************************************
// Input uses, output selects, widths, reset values
// ****************************************************
`define DPCT_IN_CLOCK    2'h0
`define DPCT_IN_GATE     2'h1
`define DPCT_IN_TRIG_NR  2'h2
`define DPCT_IN_TRIG_RT  2'h3
`define DPCT_OUT_T0      2'h0
`define DPCT_OUT_T1      2'h1
`define DPCT_OUT_CLK     2'h2
`define DPCT_INT_DIV     2'h3
`define DPCT_PRE_W       6
`define DPCT_CNT_W       8
`define DPCT_PRE_RST     6'h00
`define DPCT_CNT_RST     8'h00
`define DPCT_PRE_ONE     6'h01
`define DPCT_CNT_ONE     8'h01
`endif

// >>> core/dpct_timers.v
`timescale 1ns/10ps
`default_nettype none
`include "dpct_consts.vh"
module dpct_timers
(
    input  wire        clk,                  // System clock, 100 MHz
    input  wire        sys_rst,              // Synchronous reset, high
    input  wire [31:0] wb_adr_i,             // Wishbone byte address
    input  wire [31:0] wb_dat_i,             // Wishbone write data
    input  wire [3:0]  wb_sel_i,             // Wishbone byte select
    input  wire        wb_we_i,              // Wishbone write enable
    input  wire        wb_cyc_i,             // Wishbone cycle
    input  wire        wb_stb_i,             // Wishbone strobe
    output reg  [31:0] wb_dat_o,             // Wishbone read data
    output reg         wb_ack_o,             // Wishbone acknowledge
    input  wire        timer_input_line,     // External timer input pin
    output reg         timer_output_line,    // Timer output pin
    output reg         timer_zero_request,   // Timer zero end pulse
    output reg         timer_one_request,    // Timer one end pulse
    output reg         serial_rate_tick,     // Timer zero ticks for serial
    output reg         irq                   // Level interrupt
);

    // ****************************************************
    // Register state
    // ****************************************************
    reg  [6:0]  mode_ff;
    reg  [1:0]  ctrl0_ff;
    reg  [1:0]  ctrl1_ff;
    reg  [5:0]  pre_ld_ff [0:1];
    reg  [7:0]  cnt_ld_ff [0:1];
    reg  [5:0]  pre_ff    [0:1];
    reg  [7:0]  cnt_ff    [0:1];
    reg  [1:0]  run_ff;
    reg  [1:0]  stat_ff;
    reg  [1:0]  mask_ff;
    reg  [1:0]  divq_ff;
    reg  [1:0]  timer_output_signal_ff;
    reg         in_s1_ff;
    reg         in_s2_ff;
    reg         in_s3_ff;
    reg  [1:0]  load_req_ff;

    wire [3:0]  wadr = wb_adr_i[5:2];
    wire        wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire [1:0]  in_use = mode_ff[`DPCT_MOD_IN_HI:`DPCT_MOD_IN_LO];
    wire        in_rise = in_s2_ff & ~in_s3_ff;
    wire        int_tick = (divq_ff == `DPCT_INT_DIV);

    // ****************************************************
    // Tick sources per timer
    // ****************************************************
    wire [1:0]  tick;
    wire [1:0]  done;
    wire [1:0]  restart;
    wire        trig_mode = in_use[1];
    wire        t1_src_tick =
        mode_ff[`DPCT_MOD_CASC] ? done[0] :
        (mode_ff[`DPCT_MOD_SRCEXT] && in_use == `DPCT_IN_CLOCK) ? in_rise :
        (mode_ff[`DPCT_MOD_SRCEXT] && in_use == `DPCT_IN_GATE) ?
            (int_tick & in_s2_ff) : int_tick;
    assign tick[0] = int_tick & run_ff[0];
    assign tick[1] = t1_src_tick & run_ff[1];

    // Trigger edge loads timer one; non-retrigger only when idle
    assign restart[0] = 1'b0;
    assign restart[1] = mode_ff[`DPCT_MOD_SRCEXT] & trig_mode & in_rise &
                        ctrl1_ff[`DPCT_CTL_RUN] &
                        (~run_ff[1] | (in_use == `DPCT_IN_TRIG_RT));

    // ****************************************************
    // Prescaler and counter per timer
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_tmr
            wire [1:0] ctl = (g == 0) ? ctrl0_ff : ctrl1_ff;
            wire       cont = mode_ff[`DPCT_MOD_CONT];
            wire       pre_end = (pre_ff[g] == `DPCT_PRE_ONE);
            wire       cnt_end = (cnt_ff[g] == `DPCT_CNT_ONE);
            // End of count needs prescaler and counter at last step
            assign done[g] = tick[g] & pre_end & cnt_end;
            // Load on request; both halves restart together
            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    pre_ff[g] <= `DPCT_PRE_RST;
                    cnt_ff[g] <= `DPCT_CNT_RST;
                    run_ff[g] <= 1'b0;
                end
                else if (load_req_ff[g] | restart[g])
                begin
                    pre_ff[g] <= pre_ld_ff[g];
                    cnt_ff[g] <= cnt_ld_ff[g];
                    run_ff[g] <= ctl[`DPCT_CTL_RUN] &
                                 ~(g == 1 && mode_ff[`DPCT_MOD_SRCEXT] && trig_mode &&
                                   !restart[g]);
                end
                else if (!ctl[`DPCT_CTL_RUN] && !(g == 1 && trig_mode &&
                         mode_ff[`DPCT_MOD_SRCEXT]))
                begin
                    run_ff[g] <= 1'b0;
                end
                else if (done[g])
                begin
                    // Reload both so spacing stays constant; single pass parks at zero
                    pre_ff[g] <= pre_ld_ff[g];
                    cnt_ff[g] <= cont ? cnt_ld_ff[g] : cnt_ff[g] - `DPCT_CNT_ONE;
                    run_ff[g] <= cont;
                end
                else if (tick[g])
                begin
                    // 0 wraps to 63/255 giving divide-by-64 and 256
                    pre_ff[g] <= pre_end ? pre_ld_ff[g] : pre_ff[g] - `DPCT_PRE_ONE;
                    cnt_ff[g] <= pre_end ? cnt_ff[g] - `DPCT_CNT_ONE : cnt_ff[g];
                end
                else if (ctl[`DPCT_CTL_RUN] && !run_ff[g] && !ctl[`DPCT_CTL_LOAD] &&
                         !(g == 1 && trig_mode && mode_ff[`DPCT_MOD_SRCEXT]))
                begin
                    // Resume from held count without reload
                    run_ff[g] <= (cnt_ff[g] != `DPCT_CNT_RST) | cont;
                end
            end
        end
    endgenerate

    // ****************************************************
    // Input synchroniser and internal divide by four
    // ****************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            in_s1_ff <= 1'b0;
            in_s2_ff <= 1'b0;
            in_s3_ff <= 1'b0;
            divq_ff  <= 2'h0;
        end
        else
        begin
            in_s1_ff <= timer_input_line;
            in_s2_ff <= in_s1_ff;
            in_s3_ff <= in_s2_ff;
            divq_ff  <= divq_ff + 2'h1;
        end
    end

    // ****************************************************
    // Wishbone slave, one wait state, ack one cycle
    // ****************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0;
            mode_ff     <= 7'h00;
            ctrl0_ff    <= 2'h0;
            ctrl1_ff    <= 2'h0;
            pre_ld_ff[0] <= `DPCT_PRE_RST;
            pre_ld_ff[1] <= `DPCT_PRE_RST;
            cnt_ld_ff[0] <= `DPCT_CNT_RST;
            cnt_ld_ff[1] <= `DPCT_CNT_RST;
            mask_ff     <= 2'h0;
            stat_ff     <= 2'h0;
            load_req_ff <= 2'h0;
        end
        else
        begin
            wb_ack_o    <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            load_req_ff <= 2'h0;
            // Set wins over write-one-to-clear
            stat_ff <= (stat_ff & ~((wr && wadr == `DPCT_ADR_STAT) ? wb_dat_i[1:0] : 2'h0))
                       | done;
            if (wr)
            begin
                case (wadr)
                    `DPCT_ADR_CTRL:
                    begin
                        ctrl0_ff    <= wb_dat_i[1:0];
                        ctrl1_ff    <= wb_dat_i[9:8] & {2{wb_sel_i[1]}};
                        load_req_ff <= {wb_dat_i[8] & wb_sel_i[1], wb_dat_i[0]};
                    end
                    `DPCT_ADR_MODE:  mode_ff <= wb_dat_i[6:0];
                    `DPCT_ADR_PRE0:  pre_ld_ff[0] <= wb_dat_i[5:0];
                    `DPCT_ADR_PRE1:  pre_ld_ff[1] <= wb_dat_i[5:0];
                    `DPCT_ADR_LOAD0: cnt_ld_ff[0] <= wb_dat_i[7:0];
                    `DPCT_ADR_LOAD1: cnt_ld_ff[1] <= wb_dat_i[7:0];
                    `DPCT_ADR_MASK:  mask_ff <= wb_dat_i[1:0];
                    default:         mask_ff <= mask_ff;
                endcase
            end
            // Reads never touch counter state; prescalers unreadable
            case (wadr)
                `DPCT_ADR_CTRL:  wb_dat_o <= {22'h0, ctrl1_ff, 6'h0, ctrl0_ff};
                `DPCT_ADR_MODE:  wb_dat_o <= {25'h0, mode_ff};
                `DPCT_ADR_LOAD0: wb_dat_o <= {24'h0, cnt_ld_ff[0]};
                `DPCT_ADR_LOAD1: wb_dat_o <= {24'h0, cnt_ld_ff[1]};
                `DPCT_ADR_CNT0:  wb_dat_o <= {24'h0, cnt_ff[0]};
                `DPCT_ADR_CNT1:  wb_dat_o <= {24'h0, cnt_ff[1]};
                `DPCT_ADR_STAT:  wb_dat_o <= {30'h0, stat_ff};
                `DPCT_ADR_MASK:  wb_dat_o <= {30'h0, mask_ff};
                default:         wb_dat_o <= 32'h0;
            endcase
        end
    end

    // ****************************************************
    // Output pin, request pulses, interrupt
    // ****************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            timer_output_signal_ff            <= 2'h0;
            timer_output_line  <= 1'b0;
            timer_zero_request <= 1'b0;
            timer_one_request  <= 1'b0;
            serial_rate_tick   <= 1'b0;
            irq                <= 1'b0;
        end
        else
        begin
            // Each timer output toggles at end of count
            timer_output_signal_ff <= timer_output_signal_ff ^ done;
            case (mode_ff[`DPCT_MOD_OUT_HI:`DPCT_MOD_OUT_LO])
                `DPCT_OUT_T0:  timer_output_line <= timer_output_signal_ff[0];
                `DPCT_OUT_T1:  timer_output_line <= timer_output_signal_ff[1];
                `DPCT_OUT_CLK: timer_output_line <= divq_ff[1];
                default:       timer_output_line <= 1'b0;
            endcase
            timer_zero_request <= done[0];
            timer_one_request  <= done[1];
            serial_rate_tick   <= done[0];
            irq                <= |(stat_ff & mask_ff);
        end
    end

endmodule
`default_nettype wire
